// [logic/htxs_sched_cfg.sv]
// Host transmit endpoint schedule settings with AXI4-Lite access, NAK timers and polling.
// Operation
// - Speed field bits 7-6: 1 high, 2 full, 3 low; 0 is illegal.
// - Protocol field bits 5-4: 0 control, 1 isochronous, 2 bulk, 3 interrupt.
// - Transmit transactions go to the four-bit target endpoint in bits 3-0.
// - Endpoint 0 NAK limit m in bits 4-0 means 2^(m-1) frames.
// - Endpoint 0 halts when NAKs outlast its programmed limit.
// - A limit field of 0 or 1 disables the NAK timeout.
// - Low or full speed interrupt endpoints poll every m frames, m 1-255.
// - High speed interrupt endpoints poll every 2^(m-1) microframes, m 1-16.
// - Isochronous endpoints transfer every 2^(m-1) frames or microframes, m 1-16.
// - Bulk endpoints time out NAKs after 2^(m-1) frames, m 2-16; the code does so at high and full speed only.
// - Each transmit endpoint except 0 has its own interval, selected by index.
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "htxs_regs.svh"
module htxs_sched_cfg #(
	parameter int NUM_EP = 16 // Transmit endpoints including endpoint 0.
) (
	input wire logic aclk, // System clock, 200 MHz.
	input wire logic aresetn, // Synchronous reset, active low.
	input wire logic [7:0] awaddr, // Write address.
	input wire logic awvalid, // Write address valid.
	output logic awready, // Write address ready.
	input wire logic [31:0] wdata, // Write data.
	input wire logic [3:0] wstrb, // Write byte strobes.
	input wire logic wvalid, // Write data valid.
	output logic wready, // Write data ready.
	output logic [1:0] bresp, // Write response code.
	output logic bvalid, // Write response valid.
	input wire logic bready, // Write response ready.
	input wire logic [7:0] araddr, // Read address.
	input wire logic arvalid, // Read address valid.
	output logic arready, // Read address ready.
	output logic [31:0] rdata, // Read data.
	output logic [1:0] rresp, // Read response code.
	output logic rvalid, // Read data valid.
	input wire logic rready, // Read data ready.
	input wire logic frame_tick, // Frame or microframe start pulse.
	input wire htxs_pkg::htxs_resp_type ep0_resp, // Endpoint 0 handshake.
	input wire htxs_pkg::htxs_resp_type tx_resp, // Selected endpoint handshake.
	output htxs_pkg::htxs_target_type tx_target, // Speed, protocol and target endpoint.
	output logic [3:0] tx_sel_ep, // Selected transmit endpoint.
	output logic tx_poll_due, // One-cycle pulse: poll now.
	output logic ep0_halt, // Endpoint 0 halted by NAK timeout.
	output logic tx_halt, // Bulk endpoint halted by NAK timeout.
	output logic irq // Level interrupt.
);
	import htxs_pkg::*;

	// ****************************************
	// Bus slave state
	// ****************************************
	logic aw_hold_r;
	logic w_hold_r;
	logic [7:0] awaddr_r;
	logic [7:0] wbyte_r;
	logic wstrb0_r;
	logic awready_r;
	logic wready_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic arready_r;
	logic rvalid_r;
	logic [1:0] rresp_r;
	logic [31:0] rdata_r;

	// ****************************************
	// Configuration and status state
	// ****************************************
	htxs_target_type type_r;
	logic [4:0] nak0_r;
	logic [3:0] sel_r;
	logic [7:0] intvl_r [NUM_EP];
	logic [2:0] st_r;
	logic [2:0] mask_r;
	logic irq_r;
	logic [16:0] poll_cnt_r;
	logic poll_due_r;

	// ****************************************
	// Decode wires
	// ****************************************
	logic aw_take;
	logic w_take;
	logic ar_take;
	logic do_write;
	logic aw_hold_nxt;
	logic w_hold_nxt;
	logic bvalid_nxt;
	logic rvalid_nxt;
	logic wr_en;
	logic wr_type;
	logic wr_nak0;
	logic wr_intvl;
	logic wr_sel;
	logic wr_st;
	logic wr_mask;
	logic wr_hit;
	logic rd_hit;
	logic [7:0] rd_byte;
	logic [7:0] cur_m;
	logic [2:0] st_set;
	logic [2:0] st_nxt;
	logic ep0_tmo;
	logic tx_tmo;
	logic poll_en;
	logic lsfs_int;
	logic bulk_en;
	logic [16:0] poll_period;

	// Handshakes on each channel; a write runs once both halves are held.
	assign aw_take = awvalid && awready_r;
	assign w_take = wvalid && wready_r;
	assign ar_take = arvalid && arready_r;
	assign do_write = aw_hold_r && w_hold_r;
	assign aw_hold_nxt = aw_take || (aw_hold_r && !do_write);
	assign w_hold_nxt = w_take || (w_hold_r && !do_write);
	assign bvalid_nxt = do_write || (bvalid_r && !bready);
	assign rvalid_nxt = ar_take || (rvalid_r && !rready);

	// Registers live in byte lane 0, so only that strobe writes them.
	assign wr_en = do_write && wstrb0_r;
	assign wr_type = wr_en && (awaddr_r == `HTXS_OFF_TX_TYPE);
	assign wr_nak0 = wr_en && (awaddr_r == `HTXS_OFF_EP0_NAK);
	assign wr_intvl = wr_en && (awaddr_r == `HTXS_OFF_TX_INTVL);
	assign wr_sel = wr_en && (awaddr_r == `HTXS_OFF_EP_SEL);
	assign wr_st = wr_en && (awaddr_r == `HTXS_OFF_STATUS);
	assign wr_mask = wr_en && (awaddr_r == `HTXS_OFF_MASK);
	assign wr_hit = (awaddr_r == `HTXS_OFF_TX_TYPE) || (awaddr_r == `HTXS_OFF_EP0_NAK)
		|| (awaddr_r == `HTXS_OFF_TX_INTVL) || (awaddr_r == `HTXS_OFF_EP_SEL)
		|| (awaddr_r == `HTXS_OFF_STATUS) || (awaddr_r == `HTXS_OFF_MASK);

	// Read selection; reserved bits and unmapped words read as zero.
	assign cur_m = intvl_r[sel_r];
	assign rd_byte = (araddr == `HTXS_OFF_TX_TYPE) ? type_r :
		(araddr == `HTXS_OFF_EP0_NAK) ? {3'h0, nak0_r} :
		(araddr == `HTXS_OFF_TX_INTVL) ? cur_m :
		(araddr == `HTXS_OFF_EP_SEL) ? {4'h0, sel_r} :
		(araddr == `HTXS_OFF_STATUS) ? {5'h00, st_r} :
		(araddr == `HTXS_OFF_MASK) ? {5'h00, mask_r} : 8'h00;
	assign rd_hit = (araddr == `HTXS_OFF_TX_TYPE) || (araddr == `HTXS_OFF_EP0_NAK)
		|| (araddr == `HTXS_OFF_TX_INTVL) || (araddr == `HTXS_OFF_EP_SEL)
		|| (araddr == `HTXS_OFF_STATUS) || (araddr == `HTXS_OFF_MASK);

	// ****************************************
	// Write channels
	// ****************************************
	// Ready drops while a half is held or a response waits, so one write at a time.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			bvalid_r <= 1'b0;
		end else begin
			aw_hold_r <= aw_hold_nxt;
			w_hold_r <= w_hold_nxt;
			awready_r <= !aw_hold_nxt && !bvalid_nxt;
			wready_r <= !w_hold_nxt && !bvalid_nxt;
			bvalid_r <= bvalid_nxt;
		end
	end

	// Payload captures carry no reset; they are read only while held.
	always_ff @(posedge aclk) begin
		if (aw_take) begin
			awaddr_r <= awaddr;
		end
		if (w_take) begin
			wbyte_r <= wdata[7:0];
			wstrb0_r <= wstrb[0];
		end
		if (do_write) begin
			bresp_r <= wr_hit ? `HTXS_RESP_OKAY : `HTXS_RESP_SLVERR;
		end
	end

	// ****************************************
	// Read channel
	// ****************************************
	// Data is sampled when the address is taken and answered one cycle later.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= `HTXS_RESP_OKAY;
		end else begin
			arready_r <= !rvalid_nxt;
			rvalid_r <= rvalid_nxt;
			if (ar_take) begin
				rdata_r <= {24'h000000, rd_byte};
				rresp_r <= rd_hit ? `HTXS_RESP_OKAY : `HTXS_RESP_SLVERR;
			end
		end
	end

	// ****************************************
	// Configuration registers
	// ****************************************
	// Type fields decode straight into the enums; speed 0 is kept but flagged.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			type_r <= `HTXS_RST_TX_TYPE;
			nak0_r <= `HTXS_RST_EP0_NAK;
			sel_r <= `HTXS_RST_EP_SEL;
			mask_r <= `HTXS_RST_MASK;
		end else begin
			if (wr_type) begin
				type_r.speed <= htxs_speed_type'(wbyte_r[`HTXS_SPEED_HI:`HTXS_SPEED_LO]);
				type_r.proto <= htxs_proto_type'(wbyte_r[`HTXS_TRANSFER_PROTOCOL_SELECT_HI:`HTXS_TRANSFER_PROTOCOL_SELECT_LO]);
				type_r.ep_num <= wbyte_r[`HTXS_EPN_HI:`HTXS_EPN_LO];
			end
			if (wr_nak0) begin
				nak0_r <= wbyte_r[`HTXS_NAK0_HI:0];
			end
			if (wr_sel) begin
				sel_r <= wbyte_r[3:0];
			end
			if (wr_mask) begin
				mask_r <= wbyte_r[2:0];
			end
		end
	end

	// One interval per endpoint; entry 0 has none and stays at zero.
	for (genvar gi = 0; gi < NUM_EP; gi++) begin : g_intvl
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				intvl_r[gi] <= `HTXS_RST_INTVL;
			end else if (wr_intvl && (gi != 0) && (sel_r == 4'(gi))) begin
				intvl_r[gi] <= wbyte_r;
			end
		end
	end

	// ****************************************
	// NAK timeouts
	// ****************************************
	// Endpoint 0 runs its timer for any type and speed; the selected endpoint only as bulk at high or full speed.
	assign bulk_en = (type_r.proto == HTXS_TRANSFER_PROTOCOL_SELECT_BULK)
		&& ((type_r.speed == HTXS_SPD_HIGH) || (type_r.speed == HTXS_SPD_FULL));

	htxs_nak_timer u_ep0_timer (
		.aclk(aclk),
		.aresetn(aresetn),
		.frame_tick(frame_tick),
		.resp(ep0_resp),
		.limit_exp({3'h0, nak0_r}),
		.enable(1'b1),
		.timeout(ep0_tmo)
	);

	htxs_nak_timer u_tx_timer (
		.aclk(aclk),
		.aresetn(aresetn),
		.frame_tick(frame_tick),
		.resp(tx_resp),
		.limit_exp(cur_m),
		.enable(bulk_en),
		.timeout(tx_tmo)
	);

	// ****************************************
	// Polling scheduler
	// ****************************************
	// Interrupt at low or full speed counts plain frames; the rest use powers of two.
	assign lsfs_int = (type_r.proto == HTXS_TRANSFER_PROTOCOL_SELECT_INTR)
		&& ((type_r.speed == HTXS_SPD_FULL) || (type_r.speed == HTXS_SPD_LOW));
	assign poll_en = ((type_r.proto == HTXS_TRANSFER_PROTOCOL_SELECT_INTR) || (type_r.proto == HTXS_TRANSFER_PROTOCOL_SELECT_ISO))
		&& (type_r.speed != HTXS_SPD_ILLEGAL);
	assign poll_period = lsfs_int ? ((cur_m == 8'h00) ? 17'h00001 : {9'h000, cur_m})
		: htxs_pow_period(cur_m);

	// A shrinking period is caught by the compare, so no poll is ever lost.
	always_ff @(posedge aclk) begin
		if (!aresetn || !poll_en) begin
			poll_cnt_r <= 17'h00000;
			poll_due_r <= 1'b0;
		end else if (frame_tick) begin
			poll_due_r <= (poll_cnt_r >= poll_period - 17'h00001);
			poll_cnt_r <= (poll_cnt_r >= poll_period - 17'h00001) ? 17'h00000 : poll_cnt_r + 17'h00001;
		end else begin
			poll_due_r <= 1'b0;
		end
	end

	// ****************************************
	// Status and interrupt
	// ****************************************
	// A new event wins over a write-one clear in the same cycle.
	assign st_set = {wr_type && (wbyte_r[`HTXS_SPEED_HI:`HTXS_SPEED_LO] == 2'h0), tx_tmo, ep0_tmo};
	assign st_nxt = (st_r & ~(wr_st ? wbyte_r[2:0] : 3'h0)) | st_set;

	// Halts follow the sticky bits, so software resumes by clearing them.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= 3'h0;
			irq_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			irq_r <= |(st_nxt & mask_r);
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign awready = awready_r;
	assign wready = wready_r;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign arready = arready_r;
	assign rvalid = rvalid_r;
	assign rresp = rresp_r;
	assign rdata = rdata_r;
	assign tx_target = type_r;
	assign tx_sel_ep = sel_r;
	assign tx_poll_due = poll_due_r;
	assign ep0_halt = st_r[`HTXS_ST_EP0_TMO];
	assign tx_halt = st_r[`HTXS_ST_TX_TMO];
	assign irq = irq_r;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_speed_field: assert property (wr_type |=> tx_target.speed == $past(wbyte_r[7:6]))
		else $error("Speed field not taken from bits 7-6.");
	a_speed_illegal: assert property (wr_type && wbyte_r[7:6] == 2'h0 |=> st_r[2])
		else $error("Illegal speed not flagged.");
	a_proto_field: assert property (wr_type |=> tx_target.proto == $past(wbyte_r[5:4]))
		else $error("Protocol field not taken from bits 5-4.");
	a_target_epnum: assert property (wr_type |=> tx_target.ep_num == $past(wbyte_r[3:0]))
		else $error("Target endpoint not taken from bits 3-0.");
	a_ep0_limit: assert property (wr_nak0 |=> nak0_r == $past(wbyte_r[4:0]))
		else $error("Endpoint 0 NAK limit not stored.");
	a_ep0_halt_set: assert property (ep0_tmo |=> ep0_halt && irq == mask_r[0] || st_r[2] || st_r[1])
		else $error("Endpoint 0 not halted after timeout.");
	a_ep0_nak_off: assert property ($past(nak0_r) < 5'd2 |-> !ep0_tmo)
		else $error("Endpoint 0 timeout while disabled.");
	a_lsfs_period: assert property (lsfs_int && cur_m != 8'h00 |-> poll_period == {9'h000, cur_m})
		else $error("Low or full speed poll period is not m frames.");
	a_hs_period: assert property (type_r.proto == HTXS_TRANSFER_PROTOCOL_SELECT_INTR && type_r.speed == HTXS_SPD_HIGH
		&& cur_m == 8'h03 |-> poll_period == 17'h00004)
		else $error("High speed poll period is not two to m minus one.");
	// Frame ticks since the last poll, counted apart from the scheduler so an early poll shows up.
	logic [16:0] chk_gap_r;
	always_ff @(posedge aclk) begin
		if (!aresetn || !poll_en) begin
			chk_gap_r <= 17'h00000;
		end else if (poll_due_r) begin
			chk_gap_r <= {16'h0000, frame_tick};
		end else if (frame_tick) begin
			chk_gap_r <= chk_gap_r + 17'h00001;
		end
	end

	a_poll_gap: assert property (poll_due_r |-> $past(frame_tick) && $past(chk_gap_r) >= $past(poll_period) - 17'h00001)
		else $error("Poll raised before its period elapsed.");
	a_bulk_only: assert property (tx_tmo |-> $past(bulk_en))
		else $error("Transmit NAK timeout outside bulk.");
	a_intvl_select: assert property (wr_intvl && sel_r == 4'h2 |=> intvl_r[2] == $past(wbyte_r))
		else $error("Interval not written to the selected endpoint.");

	c_type_write: cover property (wr_type && wbyte_r[5:4] == 2'h3);
	c_ep0_timeout: cover property (ep0_tmo);
	c_bulk_timeout: cover property (tx_tmo);
	c_poll_due: cover property (poll_due_r ##1 !poll_due_r [*2] ##1 poll_due_r);

endmodule : htxs_sched_cfg

// [logic/htxs_regs.svh]
// Register offsets, field positions, reset values and bus codes of the host transmit schedule block.
`ifndef HTXS_REGS_SVH
`define HTXS_REGS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define HTXS_OFF_TX_TYPE 8'h00
`define HTXS_OFF_EP0_NAK 8'h04
`define HTXS_OFF_TX_INTVL 8'h08
`define HTXS_OFF_EP_SEL 8'h0c
`define HTXS_OFF_STATUS 8'h10
`define HTXS_OFF_MASK 8'h14

// ****************************************
// Field positions
// ****************************************
`define HTXS_SPEED_HI 7
`define HTXS_SPEED_LO 6
`define HTXS_TRANSFER_PROTOCOL_SELECT_HI 5
`define HTXS_TRANSFER_PROTOCOL_SELECT_LO 4
`define HTXS_EPN_HI 3
`define HTXS_EPN_LO 0
`define HTXS_NAK0_HI 4
`define HTXS_ST_EP0_TMO 0
`define HTXS_ST_TX_TMO 1
`define HTXS_ST_BAD_SPEED 2

// ****************************************
// Reset values and limits
// ****************************************
`define HTXS_RST_TX_TYPE 8'h00
`define HTXS_RST_EP0_NAK 5'h00
`define HTXS_RST_INTVL 8'h00
`define HTXS_RST_EP_SEL 4'h0
`define HTXS_RST_MASK 3'h0
`define HTXS_NAK_MIN_EXP 8'h02
`define HTXS_EXP_MAX 8'h10

// ****************************************
// Bus response codes
// ****************************************
`define HTXS_RESP_OKAY 2'b00
`define HTXS_RESP_SLVERR 2'b10

`endif

// [logic/htxs_pkg.sv]
// Types and helper function shared by the host transmit schedule block.
package htxs_pkg;

	// Target speed, in field encoding order.
	typedef enum logic [1:0] {HTXS_SPD_ILLEGAL, HTXS_SPD_HIGH, HTXS_SPD_FULL, HTXS_SPD_LOW} htxs_speed_type;

	// Transfer protocol, in field encoding order.
	typedef enum logic [1:0] {HTXS_TRANSFER_PROTOCOL_SELECT_CONTROL, HTXS_TRANSFER_PROTOCOL_SELECT_ISO, HTXS_TRANSFER_PROTOCOL_SELECT_BULK, HTXS_TRANSFER_PROTOCOL_SELECT_INTR} htxs_proto_type;

	// Settings handed to the host scheduler.
	typedef struct packed {
		htxs_speed_type speed;
		htxs_proto_type proto;
		logic [3:0] ep_num;
	} htxs_target_type;

	// One handshake seen from the target.
	typedef struct packed {
		logic valid;
		logic nak;
	} htxs_resp_type;

	// Two to the power m minus one, with m clamped into 1..16.
	function automatic logic [16:0] htxs_pow_period(input logic [7:0] m);
		logic [7:0] mc;
		mc = (m == 8'h00) ? 8'h01 : ((m > 8'h10) ? 8'h10 : m);
		return 17'h00001 << (mc - 8'h01);
	endfunction : htxs_pow_period

endpackage : htxs_pkg

// [logic/htxs_nak_timer.sv]
// Counter of consecutive NAK frames that flags a timeout past a power-of-two limit.
`timescale 1ns/1ps
`include "htxs_regs.svh"
module htxs_nak_timer (
	input wire logic aclk, // System clock.
	input wire logic aresetn, // Synchronous reset, active low.
	input wire logic frame_tick, // One pulse per frame or microframe.
	input wire htxs_pkg::htxs_resp_type resp, // Handshake from the target.
	input wire logic [7:0] limit_exp, // Limit exponent m.
	input wire logic enable, // Timeout applies to this transfer kind.
	output logic timeout // One-cycle pulse on timeout.
);
	import htxs_pkg::*;

	logic [16:0] cnt_r;
	logic seen_r;
	logic [16:0] limit;
	logic active;
	logic good_resp;
	logic nak_frame;

	// Field values 0 and 1 switch the timeout off completely.
	assign limit = htxs_pow_period(limit_exp);
	assign active = enable && (limit_exp >= `HTXS_NAK_MIN_EXP);
	assign good_resp = resp.valid && !resp.nak;
	assign nak_frame = frame_tick && (seen_r || (resp.valid && resp.nak));

	// A frame counts once however many NAKs it holds; any other answer restarts the count.
	always_ff @(posedge aclk) begin
		if (!aresetn || !active || good_resp) begin
			cnt_r <= 17'h00000;
			seen_r <= 1'b0;
		end else if (nak_frame) begin
			cnt_r <= (cnt_r >= limit) ? 17'h00000 : cnt_r + 17'h00001;
			seen_r <= 1'b0;
		end else if (resp.valid) begin
			seen_r <= 1'b1;
		end
	end

	// The timeout fires on the frame that takes the count past the limit.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timeout <= 1'b0;
		end else begin
			timeout <= active && !good_resp && nak_frame && (cnt_r >= limit);
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_count_clear: assert property (good_resp |=> cnt_r == 17'h00000)
		else $error("NAK count not cleared by a non-NAK answer.");
	a_timer_off: assert property (!active |=> !timeout)
		else $error("Timeout fired while disabled.");

endmodule : htxs_nak_timer

// [tb/htxs_target_model.sv]
// Behavioural attached target that answers once in every frame with a NAK or another handshake.
`timescale 1ns/1ps
module htxs_target_model (
	input wire logic aclk, // System clock.
	input wire logic aresetn, // Synchronous reset, active low.
	input wire logic frame_tick, // Frame start pulse.
	input wire logic nak_ep0, // Answer NAK on endpoint 0.
	input wire logic nak_tx, // Answer NAK on the transmit endpoint.
	output htxs_pkg::htxs_resp_type ep0_resp, // Endpoint 0 handshake.
	output htxs_pkg::htxs_resp_type tx_resp // Transmit endpoint handshake.
);
	import htxs_pkg::*;
	logic tick_d_r; // Frame start, one cycle late.
	// The answer lands two cycles into the frame.
	// Between answers the nak bit toggles, so a design that reads it without valid is caught.
	always @(posedge aclk) begin
		tick_d_r <= aresetn & frame_tick;
		if (!aresetn) begin
			ep0_resp <= '0;
			tx_resp <= '0;
		end else if (tick_d_r) begin
			ep0_resp <= '{valid: 1'b1, nak: nak_ep0};
			tx_resp <= '{valid: 1'b1, nak: nak_tx};
		end else begin
			ep0_resp <= '{valid: 1'b0, nak: ~ep0_resp.nak};
			tx_resp <= '{valid: 1'b0, nak: ~tx_resp.nak};
		end
	end
endmodule : htxs_target_model

// [tb/host_tx_endpoint_schedule_cfg_tb.sv]
// Self-checking testbench of the host transmit schedule settings block.
`timescale 1ns/1ps
`include "htxs_regs.svh"
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin n_errors++; \
	$display("[ERR] %s expected %0h seen %0h", nm, ex, got); end end
module host_tx_endpoint_schedule_cfg_tb;
	import htxs_pkg::*;
	localparam logic [1:0] OK = `HTXS_RESP_OKAY;
	localparam logic [1:0] ER = `HTXS_RESP_SLVERR;
	logic aclk = 1'b0, aresetn = 1'b0, frame_tick = 1'b0, nak_ep0 = 1'b0, nak_tx = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, tx_poll_due, ep0_halt, tx_halt, irq;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [3:0] tx_sel_ep;
	htxs_resp_type ep0_resp, tx_resp;
	htxs_target_type tx_target;
	int n_errors = 0, num_checks = 0, n_poll = 0, cyc = 0;

	htxs_sched_cfg i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .frame_tick(frame_tick), .ep0_resp(ep0_resp), .tx_resp(tx_resp),
		.tx_target(tx_target), .tx_sel_ep(tx_sel_ep), .tx_poll_due(tx_poll_due), .ep0_halt(ep0_halt),
		.tx_halt(tx_halt), .irq(irq));
	htxs_target_model i_tgt (.aclk(aclk), .aresetn(aresetn), .frame_tick(frame_tick), .nak_ep0(nak_ep0),
		.nak_tx(nak_tx), .ep0_resp(ep0_resp), .tx_resp(tx_resp));

	// Clock, poll pulse counter and a hang limit well above the fewer than a thousand cycles the tests need.
	always #2.5 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (tx_poll_due === 1'b1) n_poll <= n_poll + 1;
		if (cyc == 20000) begin
			n_errors++;
			stop_test();
		end
	end

	// Counts and verdict, the single place where the run ends.
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : stop_test

	// Bus write: each channel is released at the edge that takes it; the bench waits for the answer.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		`CHK("bresp", er, bresp)
	endtask : wr

	// Bus read compared against an expected word and response.
	task automatic rdc(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		`CHK("rdata", ex, rdata)
		`CHK("rresp", er, rresp)
	endtask : rdc

	// Frames of eight cycles, the target answering two cycles after each start.
	task automatic frames(input int n);
		repeat (n) begin
			@(posedge aclk);
			frame_tick <= 1'b1;
			@(posedge aclk);
			frame_tick <= 1'b0;
			repeat (6) @(posedge aclk);
		end
	endtask : frames

	// Reset values and the unmapped address.
	task automatic t_reset();
		rdc(`HTXS_OFF_TX_TYPE, 32'h0, OK);
		rdc(`HTXS_OFF_EP0_NAK, 32'h0, OK);
		rdc(`HTXS_OFF_TX_INTVL, 32'h0, OK);
		rdc(`HTXS_OFF_MASK, 32'h0, OK);
		rdc(8'h20, 32'h0, ER);
		wr(8'h20, 32'hff, ER);
		$display("t_reset done");
	endtask : t_reset

	// Every speed and protocol code, each with its own endpoint number, then the illegal speed flag.
	task automatic t_type();
		logic [7:0] v;
		for (int s = 0; s < 4; s++) begin
			for (int p = 0; p < 4; p++) begin
				v = {s[1:0], p[1:0], 4'(s * 4 + p)};
				wr(`HTXS_OFF_TX_TYPE, {24'h0, v}, OK);
				`CHK("target", v, tx_target)
				rdc(`HTXS_OFF_TX_TYPE, {24'h0, v}, OK);
			end
		end
		rdc(`HTXS_OFF_STATUS, 32'h4, OK);
		wr(`HTXS_OFF_STATUS, 32'h7, OK);
		rdc(`HTXS_OFF_STATUS, 32'h0, OK);
		$display("t_type done");
	endtask : t_type

	// Endpoint 0 NAK limit: disabled at 1, count cleared by an acknowledge, halt after 4 plus 1 NAK frames.
	task automatic t_nak0();
		wr(`HTXS_OFF_EP0_NAK, 32'hff, OK);
		rdc(`HTXS_OFF_EP0_NAK, 32'h1f, OK);
		wr(`HTXS_OFF_EP0_NAK, 32'h1, OK);
		nak_ep0 <= 1'b1;
		frames(8);
		`CHK("halt0", 1'b0, ep0_halt)
		nak_ep0 <= 1'b0;
		wr(`HTXS_OFF_EP0_NAK, 32'h3, OK);
		frames(1);
		nak_ep0 <= 1'b1;
		frames(4);
		nak_ep0 <= 1'b0;
		frames(1);
		nak_ep0 <= 1'b1;
		frames(4);
		`CHK("halt0", 1'b0, ep0_halt)
		frames(1);
		nak_ep0 <= 1'b0;
		`CHK("halt0", 1'b0, ep0_halt)
		frames(1);
		`CHK("halt0", 1'b1, ep0_halt)
		`CHK("irq", 1'b0, irq)
		wr(`HTXS_OFF_MASK, 32'h1, OK);
		repeat (2) @(posedge aclk);
		`CHK("irq", 1'b1, irq)
		wr(`HTXS_OFF_STATUS, 32'h1, OK);
		repeat (2) @(posedge aclk);
		`CHK("halt0", 1'b0, ep0_halt)
		`CHK("irq", 1'b0, irq)
		wr(`HTXS_OFF_EP0_NAK, 32'h0, OK);
		$display("t_nak0 done");
	endtask : t_nak0

	// Separate intervals per endpoint, then a full speed bulk NAK limit of 2 frames.
	task automatic t_bulk();
		wr(`HTXS_OFF_EP_SEL, 32'h1, OK);
		`CHK("sel", 4'h1, tx_sel_ep)
		wr(`HTXS_OFF_TX_INTVL, 32'h2, OK);
		wr(`HTXS_OFF_EP_SEL, 32'h2, OK);
		wr(`HTXS_OFF_TX_INTVL, 32'h7, OK);
		wr(`HTXS_OFF_EP_SEL, 32'h0, OK);
		wr(`HTXS_OFF_TX_INTVL, 32'h9, OK);
		rdc(`HTXS_OFF_TX_INTVL, 32'h0, OK);
		wr(`HTXS_OFF_EP_SEL, 32'h1, OK);
		rdc(`HTXS_OFF_TX_INTVL, 32'h2, OK);
		wr(`HTXS_OFF_TX_TYPE, 32'ha1, OK);
		`CHK("speed", HTXS_SPD_FULL, tx_target.speed)
		`CHK("proto", HTXS_TRANSFER_PROTOCOL_SELECT_BULK, tx_target.proto)
		frames(1);
		nak_tx <= 1'b1;
		frames(2);
		`CHK("txhalt", 1'b0, tx_halt)
		frames(1);
		nak_tx <= 1'b0;
		`CHK("txhalt", 1'b0, tx_halt)
		frames(1);
		`CHK("txhalt", 1'b1, tx_halt)
		rdc(`HTXS_OFF_STATUS, 32'h2, OK);
		wr(`HTXS_OFF_STATUS, 32'h2, OK);
		$display("t_bulk done");
	endtask : t_bulk

	// Poll pulses counted over whole periods for five speed and protocol pairings, one with the illegal speed.
	task automatic t_poll();
		logic [7:0] pt[5] = '{8'hb0, 8'h70, 8'h50, 8'h30, 8'hf0};
		int pm[5] = '{3, 3, 2, 1, 1};
		int pf[5] = '{9, 8, 8, 4, 4};
		int pe[5] = '{3, 2, 4, 0, 4};
		int c;
		for (int i = 0; i < 5; i++) begin
			wr(`HTXS_OFF_TX_TYPE, 32'h80, OK);
			wr(`HTXS_OFF_TX_INTVL, 32'(pm[i]), OK);
			wr(`HTXS_OFF_TX_TYPE, {24'h0, pt[i]}, OK);
			c = n_poll;
			frames(pf[i]);
			`CHK("polls", pe[i], n_poll - c)
		end
		rdc(`HTXS_OFF_STATUS, 32'h4, OK);
		wr(`HTXS_OFF_STATUS, 32'h7, OK);
		$display("t_poll done");
	endtask : t_poll

	// Main sequence: twelve cycles of reset, then every scenario in turn.
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_type();
		t_nak0();
		t_bulk();
		t_poll();
		stop_test();
	end
endmodule : host_tx_endpoint_schedule_cfg_tb
